// ### cws_params.svh
// timing constants for the core well power-up sequencer
// assumes a 50 MHz system clock; every figure is in its own unit first
`ifndef CWS_PARAMS_SVH
`define CWS_PARAMS_SVH

// ----------------------------------------------------------------
// clock and slow tick
// ----------------------------------------------------------------
`define CWS_CLK_PERIOD_NS 20
`define CWS_TICK_NS 32000
`define CWS_TICK_US 32
`define CWS_TICK_CYCLES ((`CWS_TICK_NS + `CWS_CLK_PERIOD_NS - 1) / `CWS_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// sequencing times, rounded up to whole ticks
// ----------------------------------------------------------------
`define CWS_PLL_LOCK_US 16000
`define CWS_PLL_LOCK_TICKS ((`CWS_PLL_LOCK_US + `CWS_TICK_US - 1) / `CWS_TICK_US)
`define CWS_STATUS_HOLD_US 1000
`define CWS_STATUS_HOLD_TICKS ((`CWS_STATUS_HOLD_US + `CWS_TICK_US - 1) / `CWS_TICK_US)
`define CWS_EARLY_RSM_TICKS 2
`define CWS_PULSE_TICKS 2
`define CWS_CNT_W 16
`define CWS_PLANE_W 3

`endif

// ### cws_pkg.sv
// types shared by the core well sequencer modules
// assumes cws_params.svh supplies every number
package cws_pkg;

  // ----------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    CWS_MOFF       = 7'h01,
    CWS_PLANE_WAIT = 7'h02,
    CWS_PLL_WAIT   = 7'h04,
    CWS_CLK_HOLD   = 7'h08,
    CWS_BUS_RST    = 7'h10,
    CWS_CPU_RST    = 7'h20,
    CWS_ON         = 7'h40
  } cws_state_t;

  // three-state drive of a clock-stop pin
  typedef struct packed {
    logic drive;
    logic level;
  } cws_stop_pin_t;

endpackage : cws_pkg

// ### cws_power_model.sv
// behavioural board supplies and clock synthesizer beside the sequencer
// assumes the bench commands the supply levels; stop pins carry board pull-ups
`timescale 1ns/1ps
module cws_power_model (
  input wire logic clk,
  input wire logic rsm_cmd,
  input wire logic pg_cmd,
  input wire logic cpu_stop_n,
  input wire logic cpu_stop_oe,
  input wire logic pci_stop_n,
  input wire logic pci_stop_oe,
  output logic suspend_well_reset_n,
  output logic core_power_good,
  output logic clocks_running
);
  logic cpu_line;
  logic pci_line;
  logic [1:0] run_pipe;

  // a floating stop pin reads high through its pull-up
  assign cpu_line = cpu_stop_oe ? cpu_stop_n : 1'b1;
  assign pci_line = pci_stop_oe ? pci_stop_n : 1'b1;

  // supplies simply follow the bench, glitch free
  assign suspend_well_reset_n = rsm_cmd;
  assign core_power_good = pg_cmd;

  // bus clock is modelled as the system clock; restart two periods late
  always_ff @(posedge clk) begin
    run_pipe <= {run_pipe[0], cpu_line & pci_line};
  end
  assign clocks_running = run_pipe[1];
endmodule : cws_power_model

// ### cws_seq_top.sv
// core well power-up sequencer: clock stop, resets, sleep and suspend status
// assumes suspend well reset and core power good arrive as asynchronous pins
`timescale 1ns/1ps
`include "cws_params.svh"
module cws_seq_top #(
  parameter int TICK_CYCLES = `CWS_TICK_CYCLES,
  parameter int PLL_TICKS = `CWS_PLL_LOCK_TICKS,
  parameter int HOLD_TICKS = `CWS_STATUS_HOLD_TICKS
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SUSPEND_WELL_RESET_N,
  input wire logic CORE_POWER_GOOD,
  output logic CPU_CLOCK_STOP_N,
  output logic CPU_CLOCK_STOP_OE,
  output logic PCI_CLOCK_STOP_N,
  output logic PCI_CLOCK_STOP_OE,
  output logic PCI_BUS_RESET_N,
  output logic PROCESSOR_RESET,
  output logic PROCESSOR_SLEEP_N,
  output logic PROCESSOR_STOP_CLOCK_N,
  output logic SUSPEND_STATUS_N,
  output logic [`CWS_PLANE_W-1:0] SUSPEND_PLANE_CTL_N,
  output logic SUSPEND_REFRESH_CLOCK
);

  // ----------------------------------------------------------------
  // input synchronisers and slow tick
  // ----------------------------------------------------------------
  logic [1:0] pins_s;
  logic rsm_s;
  logic pg_s;
  logic pg_d;
  logic pg_rise;
  logic tick;

  cws_sync #(.W(2), .INIT(2'h0)) u_sync (
    .CLK(CLK),
    .SRST(SRST),
    .async_in({SUSPEND_WELL_RESET_N, CORE_POWER_GOOD}),
    .sync_out(pins_s)
  );

  assign rsm_s = pins_s[1];
  assign pg_s = pins_s[0];

  cws_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .CLK(CLK),
    .SRST(SRST),
    .tick(tick)
  );

  // power good edge detect on the synchronised copy
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pg_d <= 1'b0;
    end else begin
      pg_d <= pg_s;
    end
  end

  assign pg_rise = pg_s && !pg_d;

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  cws_pkg::cws_state_t state;
  cws_pkg::cws_state_t next_state;
  logic [`CWS_CNT_W-1:0] cnt;
  logic pg_seen;
  logic past_pll;

  assign past_pll = state inside {cws_pkg::CWS_CLK_HOLD, cws_pkg::CWS_BUS_RST,
                                  cws_pkg::CWS_CPU_RST, cws_pkg::CWS_ON};

  // every transition waits for a tick, so all steps are tick-quantised
  always_comb begin
    next_state = state;
    if (tick) begin
      if (!rsm_s) begin
        next_state = cws_pkg::CWS_MOFF;
      end else if (!pg_s && past_pll) begin
        next_state = cws_pkg::CWS_PLL_WAIT; // core power lost: redo lock wait
      end else begin
        case (state)
          cws_pkg::CWS_MOFF: next_state = cws_pkg::CWS_PLANE_WAIT;
          cws_pkg::CWS_PLANE_WAIT: next_state = cws_pkg::CWS_PLL_WAIT;
          cws_pkg::CWS_PLL_WAIT: begin
            if (cnt >= `CWS_CNT_W'(PLL_TICKS) && pg_seen) begin
              next_state = cws_pkg::CWS_CLK_HOLD;
            end
          end
          cws_pkg::CWS_CLK_HOLD: begin
            if (cnt >= `CWS_CNT_W'(HOLD_TICKS)) begin
              next_state = cws_pkg::CWS_BUS_RST;
            end
          end
          cws_pkg::CWS_BUS_RST: next_state = cws_pkg::CWS_CPU_RST;
          cws_pkg::CWS_CPU_RST: next_state = cws_pkg::CWS_ON;
          cws_pkg::CWS_ON: next_state = cws_pkg::CWS_ON;
          default: next_state = cws_pkg::CWS_MOFF;
        endcase
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state <= cws_pkg::CWS_MOFF;
    end else begin
      state <= next_state;
    end
  end

  // ticks spent in the current state, saturating
  always_ff @(posedge CLK) begin
    if (SRST || next_state != state) begin
      cnt <= '0;
    end else if (tick && cnt != '1) begin
      cnt <= cnt + `CWS_CNT_W'(1);
    end
  end

  // power good seen high on an earlier tick guarantees a full tick of margin
  always_ff @(posedge CLK) begin
    if (SRST || !pg_s) begin
      pg_seen <= 1'b0;
    end else if (tick) begin
      pg_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // suspend well outputs
  // ----------------------------------------------------------------
  // plane controls stay active in mechanical off and the first tick after
  always_ff @(posedge CLK) begin
    if (SRST) begin
      SUSPEND_PLANE_CTL_N <= '0;
    end else begin
      SUSPEND_PLANE_CTL_N <= {`CWS_PLANE_W{!(next_state inside
        {cws_pkg::CWS_MOFF, cws_pkg::CWS_PLANE_WAIT})}};
    end
  end

  // status released only once the 1 ms clock-run hold has passed
  always_ff @(posedge CLK) begin
    if (SRST) begin
      SUSPEND_STATUS_N <= 1'b0;
    end else begin
      SUSPEND_STATUS_N <= next_state inside {cws_pkg::CWS_BUS_RST,
        cws_pkg::CWS_CPU_RST, cws_pkg::CWS_ON};
    end
  end

  // refresh clock: half period of one tick, parked low until bus reset release
  always_ff @(posedge CLK) begin
    if (SRST) begin
      SUSPEND_REFRESH_CLOCK <= 1'b0;
    end else if (!(next_state inside {cws_pkg::CWS_CPU_RST, cws_pkg::CWS_ON})) begin
      SUSPEND_REFRESH_CLOCK <= 1'b0;
    end else if (tick) begin
      SUSPEND_REFRESH_CLOCK <= !SUSPEND_REFRESH_CLOCK;
    end
  end

  // ----------------------------------------------------------------
  // core well outputs
  // ----------------------------------------------------------------
  cws_pkg::cws_stop_pin_t stop_pin;

  // float while core power is down; stop clocks until the lock wait ends
  always_ff @(posedge CLK) begin
    if (SRST) begin
      stop_pin <= '0;
    end else begin
      stop_pin.drive <= pg_s;
      stop_pin.level <= pg_s && past_pll;
    end
  end

  assign CPU_CLOCK_STOP_N = stop_pin.level;
  assign CPU_CLOCK_STOP_OE = stop_pin.drive;
  assign PCI_CLOCK_STOP_N = stop_pin.level;
  assign PCI_CLOCK_STOP_OE = stop_pin.drive;

  // resets follow power good at once, not at the next tick
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PCI_BUS_RESET_N <= 1'b0;
      PROCESSOR_RESET <= 1'b1;
    end else begin
      PCI_BUS_RESET_N <= pg_s && (next_state inside
        {cws_pkg::CWS_CPU_RST, cws_pkg::CWS_ON});
      PROCESSOR_RESET <= !(pg_s && next_state == cws_pkg::CWS_ON);
    end
  end

  // ----------------------------------------------------------------
  // processor sleep and stop-clock
  // ----------------------------------------------------------------
  logic [1:0] rsm_ticks;
  logic early;
  logic [1:0] pulse_left;

  // ticks of suspend release seen before power good comes up
  always_ff @(posedge CLK) begin
    if (SRST || !rsm_s) begin
      rsm_ticks <= 2'h0;
    end else if (tick && !pg_s && rsm_ticks != 2'(`CWS_EARLY_RSM_TICKS)) begin
      rsm_ticks <= rsm_ticks + 2'h1;
    end
  end

  assign early = rsm_ticks == 2'(`CWS_EARLY_RSM_TICKS);

  // pulse ends on the second tick after the rise: one to two ticks long
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PROCESSOR_SLEEP_N <= 1'b1;
      pulse_left <= 2'h0;
    end else if (!pg_s) begin
      PROCESSOR_SLEEP_N <= !rsm_s;
      pulse_left <= 2'h0;
    end else if (pg_rise) begin
      PROCESSOR_SLEEP_N <= early;
      pulse_left <= early ? 2'h0 : 2'(`CWS_PULSE_TICKS);
    end else if (tick && pulse_left != 2'h0) begin
      pulse_left <= pulse_left - 2'h1;
      if (pulse_left == 2'h1) begin
        PROCESSOR_SLEEP_N <= 1'b1;
      end
    end
  end

  // stop-clock moves with sleep in every case covered here
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PROCESSOR_STOP_CLOCK_N <= 1'b1;
    end else if (!pg_s) begin
      PROCESSOR_STOP_CLOCK_N <= !rsm_s;
    end else if (pg_rise) begin
      PROCESSOR_STOP_CLOCK_N <= early;
    end else if (tick && pulse_left == 2'h1) begin
      PROCESSOR_STOP_CLOCK_N <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] pulse_age;

  // cycles since the last power good rise, for the pulse-length check
  always_ff @(posedge CLK) begin
    if (SRST || pg_rise) begin
      pulse_age <= 16'h0000;
    end else if (pulse_age != 16'hffff) begin
      pulse_age <= pulse_age + 16'h0001;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_pg_low;
    !pg_s;
  endsequence

  sequence s_pg_rise;
    pg_s && !pg_d;
  endsequence

  chk_stop_float: assert property (s_pg_low |=>
    !CPU_CLOCK_STOP_OE && !PCI_CLOCK_STOP_OE)
    else $error("clock-stop pins driven while power good low");
  chk_bus_reset: assert property (s_pg_low |=> !PCI_BUS_RESET_N)
    else $error("bus reset not asserted while power good low");
  chk_cpu_reset: assert property (s_pg_low |=> PROCESSOR_RESET)
    else $error("processor reset not asserted while power good low");
  chk_sleep_idle: assert property ((!pg_s && !rsm_s) |=>
    PROCESSOR_SLEEP_N && PROCESSOR_STOP_CLOCK_N)
    else $error("sleep active although suspend well still in reset");
  chk_sleep_early: assert property ((!pg_s && rsm_s) |=>
    !PROCESSOR_SLEEP_N && !PROCESSOR_STOP_CLOCK_N)
    else $error("sleep inactive after early suspend release");
  chk_stop_driven: assert property ((pg_s && !past_pll) |=>
    CPU_CLOCK_STOP_OE && !CPU_CLOCK_STOP_N && PCI_CLOCK_STOP_OE && !PCI_CLOCK_STOP_N)
    else $error("clocks not held stopped during lock wait");
  chk_early_hold: assert property ((s_pg_rise and early) |=> PROCESSOR_SLEEP_N [*2])
    else $error("pulse seen after early suspend release");
  chk_pulse_len: assert property ((pulse_left != 2'h0) |->
    pulse_age <= 16'(2 * TICK_CYCLES + 1)) else $error("sleep pulse longer than two ticks");
  // stop level rises a cycle after the state change that clears cnt, so look two back
  chk_pll_wait: assert property ($rose(CPU_CLOCK_STOP_N) |->
    $past(cnt, 2) >= `CWS_CNT_W'(PLL_TICKS)) else $error("clocks released before lock wait");
  chk_pg_margin: assert property ($rose(CPU_CLOCK_STOP_N) |-> $past(pg_seen))
    else $error("clocks released within a tick of power good");
  chk_status_hold: assert property ($rose(SUSPEND_STATUS_N) |->
    CPU_CLOCK_STOP_N && $past(cnt) >= `CWS_CNT_W'(HOLD_TICKS))
    else $error("suspend status released too early");
  chk_refresh_run: assert property ((tick && pg_s && rsm_s &&
    state == cws_pkg::CWS_ON) |=> $changed(SUSPEND_REFRESH_CLOCK))
    else $error("refresh clock not toggling");
  chk_bus_order: assert property ($rose(PCI_BUS_RESET_N) |-> SUSPEND_STATUS_N)
    else $error("bus reset released before suspend status");
  chk_cpu_last: assert property ($fell(PROCESSOR_RESET) |->
    PCI_BUS_RESET_N && SUSPEND_STATUS_N) else $error("processor reset released out of order");
  chk_plane_release: assert property ((tick && rsm_s &&
    state == cws_pkg::CWS_PLANE_WAIT) |=> &SUSPEND_PLANE_CTL_N)
    else $error("plane controls not released on second tick");

endmodule : cws_seq_top

// ### cws_seq_top_test.sv
// self-checking bench for the core well power-up sequencer
// assumes short tick and wait parameters so a full power-up fits a short run
`timescale 1ns/1ps
`include "cws_params.svh"
module cws_seq_top_test;
  // ----------------------------------------------------------------
  // shortened timing and bench state
  // ----------------------------------------------------------------
  localparam int TC = 8;
  localparam int PLL = 8;
  localparam int HOLD = 2;
  localparam int S_PLANE = 0, S_OE = 1, S_STOP = 2, S_STAT = 3;
  localparam int S_BRST = 4, S_PRST = 5, S_SLEEP = 6, S_REF = 7;
  logic clk, srst, rsm_cmd, pg_cmd, rsm_pin, pg_pin, clk_run;
  logic cpu_n, cpu_oe, pci_n, pci_oe, brst_n, prst, sleep_n, stopclk_n, stat_n, ref_clk;
  logic [`CWS_PLANE_W-1:0] plane_n;
  int err_total;
  int n_compared;

  cws_seq_top #(.TICK_CYCLES(TC), .PLL_TICKS(PLL), .HOLD_TICKS(HOLD)) cws_seq_top_inst (
    .CLK(clk), .SRST(srst), .SUSPEND_WELL_RESET_N(rsm_pin), .CORE_POWER_GOOD(pg_pin),
    .CPU_CLOCK_STOP_N(cpu_n), .CPU_CLOCK_STOP_OE(cpu_oe), .PCI_CLOCK_STOP_N(pci_n),
    .PCI_CLOCK_STOP_OE(pci_oe), .PCI_BUS_RESET_N(brst_n), .PROCESSOR_RESET(prst),
    .PROCESSOR_SLEEP_N(sleep_n), .PROCESSOR_STOP_CLOCK_N(stopclk_n),
    .SUSPEND_STATUS_N(stat_n), .SUSPEND_PLANE_CTL_N(plane_n),
    .SUSPEND_REFRESH_CLOCK(ref_clk));

  cws_power_model cws_power_model_inst (
    .clk(clk), .rsm_cmd(rsm_cmd), .pg_cmd(pg_cmd), .cpu_stop_n(cpu_n),
    .cpu_stop_oe(cpu_oe), .pci_stop_n(pci_n), .pci_stop_oe(pci_oe),
    .suspend_well_reset_n(rsm_pin), .core_power_good(pg_pin), .clocks_running(clk_run));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  function automatic logic sig(input int k);
    case (k)
      S_PLANE: return &plane_n;
      S_OE: return cpu_oe;
      S_STOP: return cpu_n;
      S_STAT: return stat_n;
      S_BRST: return brst_n;
      S_PRST: return prst;
      S_SLEEP: return sleep_n;
      default: return ref_clk;
    endcase
  endfunction : sig

  // inputs move and outputs are read 2 ns after the rising edge
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      #2;
    end
  endtask : step

  task automatic chk(input string nm, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
      err_total++;
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    n_compared++;
    if (got < lo || got > hi) begin
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      err_total++;
    end
  endtask : chk_rng

  // bounded wait; a miss shows as a count past the upper bound
  task automatic wait_chk(input string nm, input int k, input logic v, input int lo,
                          input int hi, output int n);
    n = 0;
    while (sig(k) !== v && n <= hi) begin
      step(1);
      n++;
    end
    chk_rng(nm, lo, hi, n);
  endtask : wait_chk

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("stop oe", 1'b0, cpu_oe);
    chk("bus reset", 1'b0, brst_n);
    chk("cpu reset", 1'b1, prst);
    chk("status", 1'b0, stat_n);
    chk("plane", 1'b0, |plane_n);
  endtask : t_reset

  // suspend well released early, then a full power-up to on
  task automatic t_early_up;
    int n;
    int m;
    logic held;
    rsm_cmd = 1'b1;
    wait_chk("plane release", S_PLANE, 1'b1, TC, 2 * TC + 4, n);
    step(3 * TC);
    pg_cmd = 1'b1;
    m = 3 * TC;
    wait_chk("stop drive", S_OE, 1'b1, 0, TC, n);
    m += n;
    chk("cpu stop", 1'b0, cpu_n);
    chk("pci stop", 1'b0, pci_n);
    chk("pci drive", 1'b1, pci_oe);
    held = 1'b1;
    repeat (2 * TC) begin
      step(1);
      held &= (sleep_n === 1'b1) && (stopclk_n === 1'b1);
    end
    chk("sleep held", 1'b1, held);
    m += 2 * TC;
    wait_chk("clock release", S_STOP, 1'b1, 0, PLL * TC, n);
    chk("pci release", 1'b1, pci_n);
    chk_rng("lock wait", PLL * TC, PLL * TC + 3 * TC, m + n);
    wait_chk("status hold", S_STAT, 1'b1, HOLD * TC, HOLD * TC + TC + 2, n);
    chk("clocks up", 1'b1, clk_run);
    wait_chk("bus reset off", S_BRST, 1'b1, 0, TC + 2, n);
    wait_chk("cpu reset off", S_PRST, 1'b0, 0, TC + 2, n);
    chk("bus reset first", 1'b1, brst_n);
    wait_chk("refresh high", S_REF, 1'b1, 0, TC + 2, n);
    wait_chk("refresh low", S_REF, 1'b0, 1, TC + 2, n);
  endtask : t_early_up

  // core power lost while running, suspend well stays up
  task automatic t_pg_loss;
    int n;
    pg_cmd = 1'b0;
    wait_chk("stop float", S_OE, 1'b0, 0, TC, n);
    chk("pci float", 1'b0, pci_oe);
    chk("bus reset", 1'b0, brst_n);
    chk("cpu reset", 1'b1, prst);
    chk("sleep on", 1'b0, sleep_n);
    chk("stopclk on", 1'b0, stopclk_n);
  endtask : t_pg_loss

  // power good arrives well after the lock wait has run out
  task automatic t_late_pg;
    int n;
    step(PLL * TC + 4 * TC);
    chk("bus reset held", 1'b0, brst_n);
    pg_cmd = 1'b1;
    wait_chk("late release", S_STOP, 1'b1, TC, 2 * TC + 4, n);
  endtask : t_late_pg

  // both status inputs dropped, then raised together
  task automatic t_both_up;
    int n;
    int m;
    pg_cmd = 1'b0;
    step(TC);
    rsm_cmd = 1'b0;
    wait_chk("sleep idle", S_SLEEP, 1'b1, 0, TC, n);
    chk("stopclk idle", 1'b1, stopclk_n);
    step(3 * TC);
    rsm_cmd = 1'b1;
    pg_cmd = 1'b1;
    wait_chk("pulse start", S_SLEEP, 1'b0, 0, 4, m);
    chk("pulse pair", 1'b0, stopclk_n);
    wait_chk("pulse end", S_SLEEP, 1'b1, 0, 2 * TC + 4, n);
    chk_rng("pulse length", TC, 2 * TC + 4, m + n);
    chk("pulse pair end", 1'b1, stopclk_n);
  endtask : t_both_up

  // ----------------------------------------------------------------
  // clock, sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    srst = 1'b1;
    rsm_cmd = 1'b0;
    pg_cmd = 1'b0;
    err_total = 0;
    n_compared = 0;
    step(6);
    t_reset();
    srst = 1'b0;
    t_early_up();
    t_pg_loss();
    t_late_pg();
    t_both_up();
    test_done();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    $display("[ERR] watchdog expected done seen hang");
    err_total++;
    test_done();
  end
endmodule : cws_seq_top_test

// ### cws_sync.sv
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous levels; reset value is a parameter
`timescale 1ns/1ps
module cws_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // ----------------------------------------------------------------
  // first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      meta <= INIT;
      sync_out <= INIT;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : cws_sync

// ### cws_tick_gen.sv
// slow sequencer tick of about 32 us
// assumes one free-running system clock
`timescale 1ns/1ps
module cws_tick_gen #(
  parameter int TICK_CYCLES = 1600
) (
  input wire logic CLK,
  input wire logic SRST,
  output logic tick
);

  logic [15:0] div;

  // ----------------------------------------------------------------
  // divider; tick is one cycle wide
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      div <= 16'h0000;
      tick <= 1'b0;
    end else if (div == 16'(TICK_CYCLES - 1)) begin
      div <= 16'h0000;
      tick <= 1'b1;
    end else begin
      div <= div + 16'h0001;
      tick <= 1'b0;
    end
  end

  chk_tick_single: assert property (@(posedge CLK) disable iff (SRST)
    tick |=> !tick) else $error("tick lasted more than one cycle");

endmodule : cws_tick_gen
